// file: inc/tsc_cfg.svh
// Constants for the transmit status and control block
//----------------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------------
// Overview of operation
// - Eight-bit register: clock source, nine-bit, enable, mode, break, high baud, empty, ninth bit
// - Reset clears all bits except the empty flag, which resets to one and is read-only
// - Synchronous mode: clock source set means master clock from baud generator, clear means slave
// - Asynchronous mode ignores the clock source bit
// - Nine-bit select chooses nine-bit frames when set, eight-bit frames when clear
// - Transmitter runs only while transmit enable is set
// - Synchronous mode: either receive enable overrides transmit enable
// - Mode bit set selects synchronous, clear selects asynchronous operation
// - Async break request sends a break next; hardware clears it when done; sync ignores it
// - Async high baud select picks the fast range; unused in synchronous mode
// - Empty flag reads one while shift register holds no data, zero while full
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

//----------------------------------------------------------------------
// Register offsets
//----------------------------------------------------------------------
`define TSC_OFF_CTRL    12'h000
`define TSC_OFF_DATA    12'h004
`define TSC_OFF_IRQ_ST  12'h008
`define TSC_OFF_IRQ_MSK 12'h00c
`define TSC_OFF_BAUD    12'h010

//----------------------------------------------------------------------
// Field positions
//----------------------------------------------------------------------
`define TSC_B_CLOCK_SOURCE_MASTER 7
`define TSC_B_NINE 6
`define TSC_B_TRANSMIT_ENABLE_BIT 5
`define TSC_B_SYNC 4
`define TSC_B_BRK  3
`define TSC_B_HIGH 2
`define TSC_B_EMPT 1
`define TSC_B_D9   0
`define TSC_I_DONE 0
`define TSC_I_BRK  1

//----------------------------------------------------------------------
// Reset values and timing
//----------------------------------------------------------------------
`define TSC_CTRL_RST 8'h02
`define TSC_BAUD_RST 16'h0003
`define TSC_BREAK_BITS 4'hc

`endif

// file: inc/tsc_pkg.sv
// Types for the transmit status and control block
package tsc_pkg;
   typedef enum logic [1:0] {
      TSC_IDLE  = 2'b00,
      TSC_SHIFT = 2'b01
   } tsc_state_t;
endpackage : tsc_pkg

// file: core/tsc_baud.sv
// Baud tick generator with low and high speed ranges
`include "tsc_cfg.svh"
module tsc_baud #(
   parameter int DIV_W = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             run,
   input  wire logic             high_speed,
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick
);
   initial begin
      if (DIV_W < 4) $error("tsc_baud: DIV_W too small");
   end

   logic [DIV_W+1:0] cnt_q;
   logic [DIV_W+1:0] cnt_d;
   logic [DIV_W+1:0] limit;
   logic             tick_d;
   logic             tick_q;

   // Low range divides four times slower than high range
   always_comb begin
      limit  = high_speed ? {2'b00, divisor} : {divisor, 2'b11};
      tick_d = 1'b0;
      cnt_d  = cnt_q + {{(DIV_W+1){1'b0}}, 1'b1};
      if (!run) begin
         cnt_d = '0;
      end else if (cnt_q >= limit) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   // Counter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : tsc_baud

// file: core/tsc_sync3.sv
// Three-stage input synchroniser with agreement of last two stages
module tsc_sync3 (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic din,
   output logic      dout
);
   logic [2:0] s_q;
   logic [2:0] s_d;
   logic       o_q;
   logic       o_d;

   // Output changes only once stages two and three agree
   always_comb begin
      s_d = {s_q[1:0], din};
      o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
   end

   // Stage registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= 3'h0;
         o_q <= 1'b0;
      end else begin
         s_q <= s_d;
         o_q <= o_d;
      end
   end

   assign dout = o_q;
endmodule : tsc_sync3

// file: core/tsc_top.sv
// Transmit status and control register with transmit shifter and APB slave
//
// Implementation choices: the APB register port and the register offsets.
`include "tsc_cfg.svh"
module tsc_top #(
   parameter int DIV_W = 16
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        single_receive_enable,
   input  wire logic        continuous_receive_enable,
   input  wire logic        ext_clk_in,
   output logic             tx_out,
   output logic             clk_out,
   output logic             clk_oe,
   output logic             irq
);
   initial begin
      if (DIV_W < 4 || DIV_W > 16) $error("tsc_top: DIV_W out of range");
   end

   //-------------------------------------------------------------------
   // Register state
   //-------------------------------------------------------------------
   logic [7:0]       ctrl_q, ctrl_d;          // Control register, empty bit unused here
   logic [8:0]       buf_q, buf_d;            // Transmit buffer
   logic             buf_full_q, buf_full_d;
   logic [1:0]       ist_q, ist_d;
   logic [1:0]       imsk_q, imsk_d;
   logic [DIV_W-1:0] baud_q, baud_d;
   logic [31:0]      prdata_q, prdata_d;
   logic             pready_q, pready_d;
   logic             pslverr_q, pslverr_d;
   logic             irq_q, irq_d;

   //-------------------------------------------------------------------
   // Shifter state
   //-------------------------------------------------------------------
   tsc_pkg::tsc_state_t st_q, st_d;
   logic [11:0]      sh_q, sh_d;              // Frame bits, LSB first
   logic [3:0]       nbit_q, nbit_d;
   logic             empty_q, empty_d;
   logic             tx_q, tx_d;
   logic             ck_q, ck_d;
   logic             oe_q, oe_d;
   logic             brk_frame_q, brk_frame_d;

   logic             tick;
   logic             ext_clk_s;
   logic             ext_clk_p_q, ext_clk_p_d;
   logic             sync_mode, tx_run, shift_ev, acc, wr, rd;
   logic             done_ev, brk_done_ev;

   // Pin clock is asynchronous to pclk
   tsc_sync3 u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (ext_clk_in),
      .dout    (ext_clk_s)
   );

   // Async high baud only; sync mode always uses the fast range
   // baud range
   tsc_baud #(.DIV_W(DIV_W)) u_baud (
      .pclk       (pclk),
      .presetn    (presetn),
      .run        (tx_run),
      .high_speed (ctrl_q[`TSC_B_HIGH] | sync_mode),
      .divisor    (baud_q),
      .tick       (tick)
   );

   //-------------------------------------------------------------------
   // Mode decode
   //-------------------------------------------------------------------
   // mode select
   assign sync_mode = ctrl_q[`TSC_B_SYNC];
   assign tx_run = ctrl_q[`TSC_B_TRANSMIT_ENABLE_BIT] &
                   ~(sync_mode & (single_receive_enable | continuous_receive_enable));
   // clock source: master counts ticks, slave counts rising pin edges
   assign shift_ev = (sync_mode && !ctrl_q[`TSC_B_CLOCK_SOURCE_MASTER]) ? (ext_clk_s & ~ext_clk_p_q) : tick;

   // Single-cycle access phase, no wait states
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;

   //-------------------------------------------------------------------
   // Shifter next state
   //-------------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      sh_d        = sh_q;
      nbit_d      = nbit_q;
      empty_d     = empty_q;
      tx_d        = tx_q;
      ck_d        = ck_q;
      oe_d        = sync_mode & ctrl_q[`TSC_B_CLOCK_SOURCE_MASTER] & tx_run;
      brk_frame_d = brk_frame_q;
      buf_full_d  = buf_full_q;
      done_ev     = 1'b0;
      brk_done_ev = 1'b0;
      ext_clk_p_d = ext_clk_s;
      if (!tx_run) begin
         st_d    = tsc_pkg::TSC_IDLE;
         empty_d = 1'b1;
         tx_d    = 1'b1;
         ck_d    = 1'b0;
      end else begin
         case (st_q)
            tsc_pkg::TSC_IDLE: begin
               tx_d = 1'b1;
               // break goes out next, async only
               if (ctrl_q[`TSC_B_BRK] && !sync_mode) begin
                  sh_d        = 12'h000;
                  nbit_d      = `TSC_BREAK_BITS;
                  brk_frame_d = 1'b1;
                  st_d        = tsc_pkg::TSC_SHIFT;
                  empty_d     = 1'b0;
               end else if (buf_full_q) begin
                  if (sync_mode) begin
                     sh_d   = {3'h0, buf_q};
                     nbit_d = ctrl_q[`TSC_B_NINE] ? 4'h9 : 4'h8;
                  end else if (ctrl_q[`TSC_B_NINE]) begin
                     // Start bit leaves on the first tick, so every bit lasts a full period
                     sh_d   = {2'b01, buf_q, 1'b0};
                     nbit_d = 4'hb;
                  end else begin
                     sh_d   = {3'b001, buf_q[7:0], 1'b0};
                     nbit_d = 4'ha;
                  end
                  brk_frame_d = 1'b0;
                  buf_full_d  = 1'b0;
                  empty_d     = 1'b0;
                  st_d        = tsc_pkg::TSC_SHIFT;
               end
            end
            tsc_pkg::TSC_SHIFT: begin
               if (shift_ev) begin
                  ck_d = ~ck_q;
                  if (!sync_mode || ck_q || !ctrl_q[`TSC_B_CLOCK_SOURCE_MASTER]) begin
                     if (nbit_q == 4'h0) begin
                        empty_d     = 1'b1;
                        tx_d        = 1'b1;
                        st_d        = tsc_pkg::TSC_IDLE;
                        done_ev     = 1'b1;
                        brk_done_ev = brk_frame_q;
                        brk_frame_d = 1'b0;
                     end else begin
                        tx_d   = sh_q[0];
                        sh_d   = sh_q >> 1;
                        nbit_d = nbit_q - 4'h1;
                     end
                  end
               end
            end
            default: st_d = tsc_pkg::TSC_IDLE;
         endcase
      end
      // A buffer write in the same cycle as a load refills it
      if (wr && paddr == `TSC_OFF_DATA) begin
         buf_full_d = 1'b1;
      end
   end

   //-------------------------------------------------------------------
   // Register next state
   //-------------------------------------------------------------------
   always_comb begin
      ctrl_d    = ctrl_q;
      buf_d     = buf_q;
      ist_d     = ist_q;
      imsk_d    = imsk_q;
      baud_d    = baud_q;
      prdata_d  = 32'h0000_0000;
      pready_d  = psel & ~penable;
      pslverr_d = 1'b0;
      // Hardware sets win over a software clear
      if (wr && paddr == `TSC_OFF_IRQ_ST && pstrb[0]) ist_d = ist_q & ~pwdata[1:0];
      if (done_ev) ist_d[`TSC_I_DONE] = 1'b1;
      if (brk_done_ev) ist_d[`TSC_I_BRK] = 1'b1;
      if (psel && !penable) begin
         case (paddr)
            // empty flag reads live, not writable
            `TSC_OFF_CTRL:    prdata_d = {24'h0, ctrl_q[7:2], empty_q, ctrl_q[0]};
            `TSC_OFF_DATA:    prdata_d = {23'h0, buf_q};
            `TSC_OFF_IRQ_ST:  prdata_d = {30'h0, ist_q};
            `TSC_OFF_IRQ_MSK: prdata_d = {30'h0, imsk_q};
            `TSC_OFF_BAUD:    prdata_d = {{(32-DIV_W){1'b0}}, baud_q};
            default:          pslverr_d = 1'b1;
         endcase
      end
      if (wr) begin
         case (paddr)
            `TSC_OFF_CTRL: begin
               if (pstrb[0]) begin
                  ctrl_d = pwdata[7:0];
                  ctrl_d[`TSC_B_EMPT] = 1'b0;
               end
            end
            `TSC_OFF_DATA: begin
               // ninth bit taken from control at buffer write
               if (pstrb[0]) buf_d = {ctrl_q[`TSC_B_D9], pwdata[7:0]};
            end
            `TSC_OFF_IRQ_MSK: if (pstrb[0]) imsk_d = pwdata[1:0];
            `TSC_OFF_BAUD:    baud_d = pwdata[DIV_W-1:0];
            default:          ;
         endcase
      end
      // hardware clears break request when break completes
      if (brk_done_ev) ctrl_d[`TSC_B_BRK] = 1'b0;
      irq_d = |(ist_q & imsk_q);
   end

   //-------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q      <= `TSC_CTRL_RST & 8'hfd;
         empty_q     <= 1'b1;
         buf_q       <= 9'h000;
         buf_full_q  <= 1'b0;
         ist_q       <= 2'h0;
         imsk_q      <= 2'h0;
         baud_q      <= DIV_W'(`TSC_BAUD_RST);
         prdata_q    <= 32'h0000_0000;
         pready_q    <= 1'b0;
         pslverr_q   <= 1'b0;
         irq_q       <= 1'b0;
         st_q        <= tsc_pkg::TSC_IDLE;
         sh_q        <= 12'h000;
         nbit_q      <= 4'h0;
         tx_q        <= 1'b1;
         ck_q        <= 1'b0;
         oe_q        <= 1'b0;
         brk_frame_q <= 1'b0;
         ext_clk_p_q <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         empty_q     <= empty_d;
         buf_q       <= buf_d;
         buf_full_q  <= buf_full_d;
         ist_q       <= ist_d;
         imsk_q      <= imsk_d;
         baud_q      <= baud_d;
         prdata_q    <= prdata_d;
         pready_q    <= pready_d;
         pslverr_q   <= pslverr_d;
         irq_q       <= irq_d;
         st_q        <= st_d;
         sh_q        <= sh_d;
         nbit_q      <= nbit_d;
         tx_q        <= tx_d;
         ck_q        <= ck_d;
         oe_q        <= oe_d;
         brk_frame_q <= brk_frame_d;
         ext_clk_p_q <= ext_clk_p_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign irq     = irq_q;
   assign tx_out  = tx_q;
   assign clk_out = ck_q;
   assign clk_oe  = oe_q;
endmodule : tsc_top

// file: sim/tsc_checker.sv
// Port-level assertions for the transmit status and control block
`include "tsc_cfg.svh"
module tsc_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        single_receive_enable,
   input wire logic        continuous_receive_enable,
   input wire logic        ext_clk_in,
   input wire logic        tx_out,
   input wire logic        clk_out,
   input wire logic        clk_oe,
   input wire logic        irq
);
   logic [7:0] ctl_q, ctl_d;
   logic [1:0] msk_q, msk_d;
   logic       done, transmit_enable_bit, smst;
   // Shadow of software writes; break bit is not trusted since hardware clears it
   assign done = psel && penable && pready;
   assign transmit_enable_bit = ctl_q[5];
   assign smst = ctl_q[7] && ctl_q[5] && ctl_q[4];
   always_comb begin
      ctl_d = ctl_q;
      msk_d = msk_q;
      if (done && pwrite && paddr == `TSC_OFF_CTRL) ctl_d = pwdata[7:0];
      if (done && pwrite && paddr == `TSC_OFF_IRQ_MSK) msk_d = pwdata[1:0];
   end
   // Shadow registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 8'h00;
         msk_q <= 2'h0;
      end else begin
         ctl_q <= ctl_d;
         msk_q <= msk_d;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_ctl_s;
      done && !pwrite && paddr == `TSC_OFF_CTRL;
   endsequence
   a_rst_idle: assert property ($rose(presetn) |-> tx_out && !irq && !clk_oe && !pready) // idle outputs
      else $error("Outputs not idle after reset");
   a_ready_next: assert property (setup_s |=> pready) // zero wait
      else $error("No ready one cycle after setup");
   a_slverr_map: assert property (done && paddr > `TSC_OFF_BAUD |-> pslverr && prdata == 32'h0) // unmapped
      else $error("Unmapped access not refused");
   a_ctl_read: assert property (rd_ctl_s |-> prdata[31:8] == 24'h0 && prdata[7:4] == ctl_q[7:4]
      && prdata[2] == ctl_q[2] && prdata[0] == ctl_q[0]) // read back
      else $error("Control read differs from written value");
   a_master_clk: assert property (clk_oe |-> smst || $past(smst)) // master only
      else $error("Clock driven outside synchronous master");
   a_off_idle: assert property ((!transmit_enable_bit) [*3] |-> tx_out) // line idle
      else $error("Line active while transmit disabled");
   a_rx_first: assert property ((ctl_q[4] && (single_receive_enable || continuous_receive_enable)) [*3]
      |-> !clk_oe) // receive wins
      else $error("Transmit clock while receive enabled");
   a_empty_busy: assert property (rd_ctl_s ##0 !prdata[1] |-> transmit_enable_bit || $past(transmit_enable_bit, 2)) // full flag
      else $error("Shift register full while disabled");
   a_irq_masked: assert property ((msk_q == 2'h0) [*2] |-> !irq) // masked event
      else $error("Interrupt raised while masked");
endmodule : tsc_checker

bind tsc_top tsc_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .single_receive_enable(single_receive_enable),
   .continuous_receive_enable(continuous_receive_enable), .ext_clk_in(ext_clk_in), .tx_out(tx_out),
   .clk_out(clk_out), .clk_oe(clk_oe), .irq(irq));

// file: sim/tsc_rx_model.sv
// Behavioural far-end receiver sampling the serial line
module tsc_rx_model (
   input wire logic   pclk,
   input wire logic   tx_out,
   input wire logic   listen,
   input wire logic   nine,
   input int          bit_cyc,
   output logic [8:0] rx_data,
   output logic       stop_bad,
   output int         frames
);
   timeunit 1ns;
   timeprecision 1ps;
   int i;
   // Falling line opens a frame; bits sampled mid-period, a low stop marks a break
   initial begin
      rx_data = 9'h000;
      stop_bad = 1'b0;
      frames = 0;
      forever begin
         @(negedge tx_out iff listen);
         rx_data = 9'h000;
         repeat (bit_cyc / 2) @(posedge pclk);
         for (i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (bit_cyc) @(posedge pclk);
            rx_data[i] = tx_out;
         end
         repeat (bit_cyc) @(posedge pclk);
         stop_bad = !tx_out;
         frames++;
      end
   end
endmodule : tsc_rx_model

// file: sim/testbench.sv
// Register-level testbench for the transmit status and control block
`include "tsc_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sre = 0, cre = 0, ext = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, tx_out, clk_out, clk_oe, irq, e, stop_bad, seen, listen = 1, nine = 0;
   logic [8:0]  rx_data;
   int          bc = 2, frames, n_mismatch = 0, compares = 0, cyc = 0, k, j, f0;
   tsc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .single_receive_enable(sre), .continuous_receive_enable(cre), .ext_clk_in(ext), .tx_out(tx_out),
      .clk_out(clk_out), .clk_oe(clk_oe), .irq(irq));
   tsc_rx_model i_rx (.pclk(pclk), .tx_out(tx_out), .listen(listen), .nine(nine), .bit_cyc(bc),
      .rx_data(rx_data), .stop_bad(stop_bad), .frames(frames));
   // Clock
   always #5 pclk = ~pclk;
   task print_verdict;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   // Hang guard, well above the roughly seven hundred cycles needed
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict;
      end
   end
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      compares++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // One APB transfer; request held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready});
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, r);
   endtask : rd
   task wait_frame;
      f0 = frames;
      for (k = 0; k < 400 && frames == f0; k++) @(posedge pclk);
      chk("frame seen", 32'h1, {31'h0, frames != f0});
   endtask : wait_frame
   task wait_empty;
      for (k = 0; k < 60; k++) begin
         apb(1'b0, `TSC_OFF_CTRL, 32'h0);
         if (r[1] === 1'b1) break;
      end
      chk("empty flag", 32'h1, {31'h0, r[1]});
   endtask : wait_empty
   //----------------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TSC_OFF_CTRL, 32'h02, "ctrl reset"); // reset value
      rd(`TSC_OFF_BAUD, {16'h0, `TSC_BAUD_RST}, "baud reset");
      apb(1'b0, 12'h0fc, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      apb(1'b1, `TSC_OFF_CTRL, 32'hd5);
      rd(`TSC_OFF_CTRL, 32'hd7, "ctrl rw"); // flag read-only
      apb(1'b1, `TSC_OFF_CTRL, 32'h00);
      rd(`TSC_OFF_CTRL, 32'h02, "ctrl clear"); // flag stays set
      $display("test registers done");
      apb(1'b1, `TSC_OFF_BAUD, 32'h1);
      apb(1'b1, `TSC_OFF_IRQ_MSK, 32'h1);
      apb(1'b1, `TSC_OFF_CTRL, 32'ha4); // clock source ignored
      apb(1'b1, `TSC_OFF_DATA, 32'ha5);
      @(posedge pclk);
      rd(`TSC_OFF_CTRL, 32'ha4, "empty low"); // shift register full
      wait_frame;
      chk("rx byte", 32'ha5, {23'h0, rx_data}); // eight bits
      chk("stop", 32'h0, {31'h0, stop_bad});
      wait_empty; // flag rises after stop
      repeat (2) @(posedge pclk);
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b1, `TSC_OFF_IRQ_ST, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test async frame done");
      apb(1'b1, `TSC_OFF_IRQ_MSK, 32'h0);
      nine = 1'b1;
      apb(1'b1, `TSC_OFF_CTRL, 32'h65); // ninth bit first
      apb(1'b1, `TSC_OFF_DATA, 32'h3c);
      wait_frame;
      chk("rx nine", 32'h13c, {23'h0, rx_data}); // ninth bit sent
      wait_empty;
      rd(`TSC_OFF_IRQ_ST, 32'h1, "status sticky");
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `TSC_OFF_IRQ_ST, 32'h3);
      nine = 1'b0;
      bc = 8;
      apb(1'b1, `TSC_OFF_CTRL, 32'h20);
      apb(1'b1, `TSC_OFF_DATA, 32'h5a);
      wait_frame;
      chk("rx low", 32'h5a, {23'h0, rx_data}); // low range timing
      wait_empty;
      $display("test frame formats done");
      bc = 2;
      apb(1'b1, `TSC_OFF_CTRL, 32'h2c);
      apb(1'b1, `TSC_OFF_DATA, 32'h00);
      wait_frame;
      chk("break low", 32'h1, {31'h0, stop_bad}); // break sent
      repeat (60) @(posedge pclk);
      wait_empty;
      rd(`TSC_OFF_CTRL, 32'h26, "break cleared"); // self clearing
      apb(1'b0, `TSC_OFF_IRQ_ST, 32'h0);
      chk("break status", 32'h2, r & 32'h2);
      apb(1'b1, `TSC_OFF_CTRL, 32'h04);
      f0 = frames;
      apb(1'b1, `TSC_OFF_DATA, 32'hff);
      repeat (60) @(posedge pclk);
      chk("no frame", f0, frames); // disabled transmitter
      rd(`TSC_OFF_CTRL, 32'h06, "idle disabled");
      $display("test break and disable done");
      listen = 1'b0;
      apb(1'b1, `TSC_OFF_CTRL, 32'hb4);
      apb(1'b1, `TSC_OFF_DATA, 32'h81);
      seen = 1'b0;
      for (j = 0; j < 60; j++) begin
         @(posedge pclk);
         seen = seen | (clk_oe === 1'b1);
      end
      chk("master clock", 32'h1, {31'h0, seen}); // master drives clock
      wait_empty; // synchronous transfer
      for (j = 0; j < 2; j++) begin
         sre <= (j == 0);
         cre <= (j == 1);
         apb(1'b1, `TSC_OFF_DATA, 32'h55);
         seen = 1'b0;
         repeat (40) begin
            @(posedge pclk);
            seen = seen | (clk_oe !== 1'b0);
         end
         chk("receive priority", 32'h0, {31'h0, seen}); // receive overrides
         rd(`TSC_OFF_CTRL, 32'hb6, "held empty");
      end
      sre <= 1'b0;
      cre <= 1'b0;
      wait_empty;
      // Slave: no clock driven, frame shifts only on pin edges
      apb(1'b1, `TSC_OFF_CTRL, 32'h34);
      apb(1'b1, `TSC_OFF_DATA, 32'h3c);
      seen = 1'b0;
      repeat (40) begin
         repeat (3) @(posedge pclk);
         ext <= ~ext;
         seen = seen | (clk_oe !== 1'b0);
      end
      chk("slave no clock", 32'h0, {31'h0, seen}); // slave drives no clock
      wait_empty; // slave frame completes
      $display("test synchronous done");
      print_verdict;
   end
endmodule : testbench
